// ==== common/nca_defines.svh ====
// Constants for the nibble core: opcodes, reset values and machine-cycle timing.
`ifndef NCA_DEFINES_SVH
`define NCA_DEFINES_SVH

// ************************************************************
// Timing
// ************************************************************
`define NCA_CLK_PERIOD_NS    40
`define NCA_STATE_TIME_NS    40
`define NCA_STATE_CYCLES     ((`NCA_STATE_TIME_NS + `NCA_CLK_PERIOD_NS - 1) / `NCA_CLK_PERIOD_NS)
`define NCA_STATES_PER_CYCLE 4

// ************************************************************
// Reset values
// ************************************************************
`define NCA_PC_RESET    12'h000
`define NCA_NIB_RESET   4'h0

// ************************************************************
// One-byte opcodes
// ************************************************************
`define NCA_OP_MOV_A_M01 8'h04
`define NCA_OP_MOV_A_M23 8'h05
`define NCA_OP_MOV_M01_A 8'h06
`define NCA_OP_MOV_M23_A 8'h07
`define NCA_OP_ADC_M     8'h08
`define NCA_OP_ADD_M     8'h09
`define NCA_OP_SUB_M     8'h0a
`define NCA_OP_SBC_M     8'h0b
`define NCA_OP_INC_M01   8'h0c
`define NCA_OP_DEC_M01   8'h0d
`define NCA_OP_INC_M23   8'h0e
`define NCA_OP_DEC_M23   8'h0f
`define NCA_OP_AND_A_M   8'h1a
`define NCA_OP_OR_A_M    8'h1b
`define NCA_OP_XOR_A_M   8'h1c
`define NCA_OP_AND_M_A   8'h1d
`define NCA_OP_OR_M_A    8'h1e
`define NCA_OP_XOR_M_A   8'h1f
`define NCA_OP_CLC       8'h2a
`define NCA_OP_STC       8'h2b
`define NCA_OP_INC_A     8'h31
`define NCA_OP_DAA       8'h36
`define NCA_OP_DEC_A     8'h3f
// High nibbles of register and immediate groups.
`define NCA_GRP_INCDEC_R 4'h1
`define NCA_GRP_MOV_R    4'h2
`define NCA_GRP_MOV_A_X  4'h7
`define NCA_LAST_REG     3'h4

// ************************************************************
// Two-byte opcodes
// ************************************************************
`define NCA_OP_ADD_X     8'h40
`define NCA_OP_SUB_X     8'h41
`define NCA_OP_AND_X     8'h42
`define NCA_OP_XOR_X     8'h43
`define NCA_OP_OR_X      8'h44
`define NCA_OP_MOV_R4_X  8'h46
`define NCA_OP_MOV_P01_X 8'h50
`define NCA_OP_MOV_P23_X 8'h51

`endif

// ==== common/nca_pkg.sv ====
// Types shared by the nibble core and its arithmetic unit.
package nca_pkg;

    // Machine-cycle states, Gray coded along the sequence.
    typedef enum logic [1:0] {
        NCA_FIRST_STATE  = 2'b00,
        NCA_SECOND_STATE = 2'b01,
        NCA_THIRD_STATE  = 2'b11,
        NCA_LAST_STATE   = 2'b10
    } nca_state_t;

    // Arithmetic unit operations.
    typedef enum logic [3:0] {
        NCA_ALU_ADD  = 4'h0,
        NCA_ALU_ADC  = 4'h1,
        NCA_ALU_SUB  = 4'h2,
        NCA_ALU_SBC  = 4'h3,
        NCA_ALU_AND  = 4'h4,
        NCA_ALU_OR   = 4'h5,
        NCA_ALU_XOR  = 4'h6,
        NCA_ALU_INC  = 4'h7,
        NCA_ALU_DEC  = 4'h8,
        NCA_ALU_DAA  = 4'h9,
        NCA_ALU_PASS = 4'ha
    } nca_alu_op_t;

endpackage

// ==== core/nca_alu.sv ====
// Combinational 4-bit arithmetic and logic unit of the nibble core.
`timescale 1ns/1ps
module nca_alu
(
    input  wire logic                 i_cin,
    input  wire logic [3:0]           i_a,
    input  wire logic [3:0]           i_b,
    input  wire nca_pkg::nca_alu_op_t i_op,
    output logic      [3:0]           o_y,
    output logic                      o_cout
);

    logic [4:0] sum;

    // ************************************************************
    // Operation select
    // ************************************************************
    // Subtraction reports a borrow in the carry out, so carry set means the result wrapped.
    always_comb
    begin
        sum = 5'h00;
        o_y = i_a;
        o_cout = i_cin;
        unique case (i_op)
            nca_pkg::NCA_ALU_ADD:
            begin
                sum = {1'b0, i_a} + {1'b0, i_b};
                {o_cout, o_y} = sum;
            end
            nca_pkg::NCA_ALU_ADC:
            begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_cin};
                {o_cout, o_y} = sum;
            end
            nca_pkg::NCA_ALU_SUB:
            begin
                sum = {1'b0, i_a} - {1'b0, i_b};
                {o_cout, o_y} = sum;
            end
            nca_pkg::NCA_ALU_SBC:
            begin
                sum = {1'b0, i_a} - {1'b0, i_b} - {4'h0, i_cin};
                {o_cout, o_y} = sum;
            end
            nca_pkg::NCA_ALU_AND:  o_y = i_a & i_b;
            nca_pkg::NCA_ALU_OR:   o_y = i_a | i_b;
            nca_pkg::NCA_ALU_XOR:  o_y = i_a ^ i_b;
            nca_pkg::NCA_ALU_INC:  o_y = i_a + 4'h1; // Wraps modulo sixteen.
            nca_pkg::NCA_ALU_DEC:  o_y = i_a - 4'h1;
            nca_pkg::NCA_ALU_DAA: // RULE6 RULE15
            begin
                if ((i_a > 4'h9) || i_cin)
                begin
                    o_y = i_a + 4'h6;
                    o_cout = 1'b1;
                end
            end
            nca_pkg::NCA_ALU_PASS: o_y = i_b;
            default:               o_y = i_a;
        endcase
    end

endmodule // nca_alu

// ==== core/nca_core.sv ====
// Nibble core: machine-cycle sequencer, instruction decode, registers and data memory.
// Notes on behaviour
// (RULE1) A machine cycle is four states, first to last, one clock each.
// (RULE2) Add memory at first pointer to accumulator, set carry; one byte, one cycle.
// (RULE3) Add memory at first pointer plus carry to accumulator; one byte, one cycle.
// (RULE4) Subtract memory, or memory and borrow, from accumulator; carry updated; one cycle.
// (RULE5) Immediate add and subtract update accumulator and carry; two bytes, two cycles.
// (RULE6) Decimal adjust corrects accumulator to BCD, may set carry; one cycle.
// (RULE7) AND, OR, XOR of memory into accumulator keep carry; one cycle.
// (RULE8) AND, OR, XOR into memory write back the location, keep carry; one cycle.
// (RULE9) AND, OR, XOR with immediate into accumulator keep carry; two cycles.
// (RULE10) Move any of five working registers to or from accumulator; one cycle.
// (RULE11) Move nibble between accumulator and memory at either pointer pair; one cycle.
// (RULE12) Load immediate nibble into accumulator with a one-byte instruction.
// (RULE13) Load an immediate byte across either pointer pair; two bytes, two cycles.
// (RULE14) Load immediate nibble into the fifth working register; two cycles.
// (RULE15) Decimal adjust adds six and sets carry when above nine or carry set.
// (RULE16) Decrement accumulator, register or memory by one, carry unchanged.
// (RULE17) Increment accumulator, register or memory modulo sixteen, carry unchanged.
// (RULE18) Two-byte instructions fetch the operand next; counter passes both bytes.
`timescale 1ns/1ps
`include "nca_defines.svh"
module nca_core
#(
    parameter int PC_WIDTH  = 12,
    parameter int RAM_DEPTH = 256
)
(
    input  wire logic                I_REF_CLK,
    input  wire logic                I_RESETN,
    input  wire logic [7:0]          I_PROG_DATA,
    output logic      [PC_WIDTH-1:0] O_PROG_ADDR,
    output logic      [3:0]          O_ACC,
    output logic                     O_CARRY,
    output logic      [1:0]          O_STATE
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic is_two_byte(input logic [7:0] op);
        return (op[7:4] == 4'h4) || (op == `NCA_OP_MOV_P01_X) || (op == `NCA_OP_MOV_P23_X);
    endfunction

    function automatic logic is_reg_op(input logic [7:0] op, input logic [3:0] grp);
        return (op[7:4] == grp) && (op[3:1] <= `NCA_LAST_REG);
    endfunction

    nca_pkg::nca_state_t  state_r, state_nxt;
    logic [PC_WIDTH-1:0]  pc_r, pc_nxt, addr_r, addr_nxt;
    logic [7:0]           byte_r, byte_nxt, opc_r, opc_nxt;
    logic                 second_r, second_nxt, cf_r, cf_nxt;
    logic [3:0]           acc_r, acc_nxt;
    logic [3:0]           wr_r [0:4];
    logic [3:0]           wr_nxt [0:4];
    logic [3:0]           ram [0:RAM_DEPTH-1];
    logic                 ram_we, do_exec, cf_we;
    logic [7:0]           ram_waddr, exec_op, imm;
    logic [7:0]           ptr01, ptr23;
    logic [3:0]           mem01, mem23, alu_a, alu_b, alu_y;
    logic                 alu_cout;
    logic [2:0]           rn;
    nca_pkg::nca_alu_op_t alu_op;

    assign ptr01 = {wr_r[1], wr_r[0]};
    assign ptr23 = {wr_r[3], wr_r[2]};
    assign mem01 = ram[ptr01];
    assign mem23 = ram[ptr23];

    nca_alu u_alu
    (
        .i_cin  (cf_r),
        .i_a    (alu_a),
        .i_b    (alu_b),
        .i_op   (alu_op),
        .o_y    (alu_y),
        .o_cout (alu_cout)
    );

    // ************************************************************
    // Sequencer, fetch and execute
    // ************************************************************
    // Address leaves in the first state, the byte is taken in the third state, so program
    // memory gets two full states of settling time; results land at the end of the last state.
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        addr_nxt = addr_r;
        byte_nxt = byte_r;
        opc_nxt = opc_r;
        second_nxt = second_r;
        acc_nxt = acc_r;
        cf_nxt = cf_r;
        for (int k = 0; k < 5; k++)
        begin
            wr_nxt[k] = wr_r[k];
        end
        ram_we = 1'b0;
        ram_waddr = ptr01;
        do_exec = 1'b0;
        cf_we = 1'b0;
        exec_op = 8'h00;
        imm = 8'h00;
        alu_op = nca_pkg::NCA_ALU_PASS;
        alu_a = acc_r;
        alu_b = mem01;
        rn = 3'h0;
        unique case (state_r) // RULE1
            nca_pkg::NCA_FIRST_STATE:
            begin
                addr_nxt = pc_r;
                state_nxt = nca_pkg::NCA_SECOND_STATE;
            end
            nca_pkg::NCA_SECOND_STATE: state_nxt = nca_pkg::NCA_THIRD_STATE;
            nca_pkg::NCA_THIRD_STATE:
            begin
                byte_nxt = I_PROG_DATA;
                state_nxt = nca_pkg::NCA_LAST_STATE;
            end
            nca_pkg::NCA_LAST_STATE:
            begin
                state_nxt = nca_pkg::NCA_FIRST_STATE;
                pc_nxt = pc_r + {{(PC_WIDTH-1){1'b0}}, 1'b1}; // RULE18
                if (second_r)
                begin
                    exec_op = opc_r; // RULE18
                    imm = byte_r;
                    do_exec = 1'b1;
                    second_nxt = 1'b0;
                end
                else if (is_two_byte(byte_r))
                begin
                    opc_nxt = byte_r; // RULE18
                    second_nxt = 1'b1;
                end
                else
                begin
                    exec_op = byte_r;
                    imm = {4'h0, byte_r[3:0]};
                    do_exec = 1'b1;
                end
            end
        endcase
        rn = exec_op[3:1];
        if (do_exec)
        begin
            // Specific codes come before the register groups that share their high nibble.
            priority casez (exec_op)
                `NCA_OP_ADD_M:   begin alu_op = nca_pkg::NCA_ALU_ADD; cf_we = 1'b1; end // RULE2
                `NCA_OP_ADC_M:   begin alu_op = nca_pkg::NCA_ALU_ADC; cf_we = 1'b1; end // RULE3
                `NCA_OP_SUB_M:   begin alu_op = nca_pkg::NCA_ALU_SUB; cf_we = 1'b1; end // RULE4
                `NCA_OP_SBC_M:   begin alu_op = nca_pkg::NCA_ALU_SBC; cf_we = 1'b1; end // RULE4
                `NCA_OP_ADD_X:   begin alu_op = nca_pkg::NCA_ALU_ADD; alu_b = imm[3:0];
                                       cf_we = 1'b1; end // RULE5
                `NCA_OP_SUB_X:   begin alu_op = nca_pkg::NCA_ALU_SUB; alu_b = imm[3:0];
                                       cf_we = 1'b1; end // RULE5
                `NCA_OP_DAA:     begin alu_op = nca_pkg::NCA_ALU_DAA; cf_we = 1'b1; end // RULE6
                `NCA_OP_AND_A_M: alu_op = nca_pkg::NCA_ALU_AND; // RULE7
                `NCA_OP_OR_A_M:  alu_op = nca_pkg::NCA_ALU_OR;  // RULE7
                `NCA_OP_XOR_A_M: alu_op = nca_pkg::NCA_ALU_XOR; // RULE7
                `NCA_OP_AND_M_A: begin alu_op = nca_pkg::NCA_ALU_AND; ram_we = 1'b1; end // RULE8
                `NCA_OP_OR_M_A:  begin alu_op = nca_pkg::NCA_ALU_OR;  ram_we = 1'b1; end // RULE8
                `NCA_OP_XOR_M_A: begin alu_op = nca_pkg::NCA_ALU_XOR; ram_we = 1'b1; end // RULE8
                `NCA_OP_AND_X:   begin alu_op = nca_pkg::NCA_ALU_AND; alu_b = imm[3:0]; end // RULE9
                `NCA_OP_OR_X:    begin alu_op = nca_pkg::NCA_ALU_OR;  alu_b = imm[3:0]; end // RULE9
                `NCA_OP_XOR_X:   begin alu_op = nca_pkg::NCA_ALU_XOR; alu_b = imm[3:0]; end // RULE9
                `NCA_OP_INC_A:   alu_op = nca_pkg::NCA_ALU_INC; // RULE17
                `NCA_OP_DEC_A:   alu_op = nca_pkg::NCA_ALU_DEC; // RULE16
                `NCA_OP_INC_M01: begin alu_op = nca_pkg::NCA_ALU_INC; alu_a = mem01;
                                       ram_we = 1'b1; end // RULE17
                `NCA_OP_DEC_M01: begin alu_op = nca_pkg::NCA_ALU_DEC; alu_a = mem01;
                                       ram_we = 1'b1; end // RULE16
                `NCA_OP_INC_M23: begin alu_op = nca_pkg::NCA_ALU_INC; alu_a = mem23;
                                       ram_waddr = ptr23; ram_we = 1'b1; end // RULE17
                `NCA_OP_DEC_M23: begin alu_op = nca_pkg::NCA_ALU_DEC; alu_a = mem23;
                                       ram_waddr = ptr23; ram_we = 1'b1; end // RULE16
                `NCA_OP_MOV_A_M01: acc_nxt = mem01; // RULE11
                `NCA_OP_MOV_A_M23: acc_nxt = mem23; // RULE11
                `NCA_OP_MOV_M01_A: begin alu_b = acc_r; ram_we = 1'b1; end // RULE11
                `NCA_OP_MOV_M23_A: begin alu_b = acc_r; ram_waddr = ptr23; ram_we = 1'b1; end
                `NCA_OP_CLC:       cf_nxt = 1'b0;
                `NCA_OP_STC:       cf_nxt = 1'b1;
                `NCA_OP_MOV_R4_X:  wr_nxt[4] = imm[3:0]; // RULE14
                `NCA_OP_MOV_P01_X: {wr_nxt[1], wr_nxt[0]} = imm; // RULE13
                `NCA_OP_MOV_P23_X: {wr_nxt[3], wr_nxt[2]} = imm; // RULE13
                {`NCA_GRP_MOV_A_X, 4'h?}: acc_nxt = imm[3:0]; // RULE12
                default:
                begin
                    if (is_reg_op(exec_op, `NCA_GRP_INCDEC_R))
                    begin
                        alu_a = wr_r[rn];
                        alu_op = exec_op[0] ? nca_pkg::NCA_ALU_DEC : nca_pkg::NCA_ALU_INC;
                        wr_nxt[rn] = alu_y; // RULE16 RULE17
                    end
                    else if (is_reg_op(exec_op, `NCA_GRP_MOV_R))
                    begin
                        if (exec_op[0])
                        begin
                            wr_nxt[rn] = acc_r; // RULE10
                        end
                        else
                        begin
                            acc_nxt = wr_r[rn]; // RULE10
                        end
                    end
                end
            endcase
            // Arithmetic and logic results go to the accumulator unless memory or a working register is the target.
            if ((alu_op != nca_pkg::NCA_ALU_PASS) && !ram_we &&
                !is_reg_op(exec_op, `NCA_GRP_INCDEC_R))
            begin
                acc_nxt = alu_y;
            end
            if (cf_we)
            begin
                cf_nxt = alu_cout;
            end
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    // Data memory is not reset; its content after power-up is undefined, as in the part.
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RESETN)
        begin
            state_r <= nca_pkg::NCA_FIRST_STATE;
            pc_r <= `NCA_PC_RESET;
            addr_r <= `NCA_PC_RESET;
            byte_r <= 8'h00;
            opc_r <= 8'h00;
            second_r <= 1'b0;
            acc_r <= `NCA_NIB_RESET;
            cf_r <= 1'b0;
            wr_r <= '{default: `NCA_NIB_RESET};
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            addr_r <= addr_nxt;
            byte_r <= byte_nxt;
            opc_r <= opc_nxt;
            second_r <= second_nxt;
            acc_r <= acc_nxt;
            cf_r <= cf_nxt;
            wr_r <= wr_nxt;
            if (ram_we)
            begin
                ram[ram_waddr] <= alu_y;
            end
        end
    end

    assign O_PROG_ADDR = addr_r;
    assign O_ACC = acc_r;
    assign O_CARRY = cf_r;
    assign O_STATE = state_r;

    // ************************************************************
    // Checks
    // ************************************************************
    state_walk_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE1
        state_r == nca_pkg::NCA_FIRST_STATE |=> state_r == nca_pkg::NCA_SECOND_STATE
        ##1 state_r == nca_pkg::NCA_THIRD_STATE ##1 state_r == nca_pkg::NCA_LAST_STATE
        ##1 state_r == nca_pkg::NCA_FIRST_STATE)
        else $error("Machine cycle states out of order.");

    pc_two_byte_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE18
        (state_r == nca_pkg::NCA_LAST_STATE && !second_r && is_two_byte(byte_r))
        |-> ##5 (pc_r == $past(pc_r, 5) + {{(PC_WIDTH-2){1'b0}}, 2'b10}) && !second_r)
        else $error("Two-byte instruction did not advance the counter by two.");

    add_mem_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE2
        (do_exec && exec_op == `NCA_OP_ADD_M)
        |=> {cf_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(mem01)})
        else $error("Add from memory gave a wrong sum or carry.");

    adc_mem_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE3
        (do_exec && exec_op == `NCA_OP_ADC_M)
        |=> {cf_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(mem01)} + {4'h0, $past(cf_r)})
        else $error("Add with carry gave a wrong sum or carry.");

    carry_kept_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE7
        (do_exec && !cf_we && exec_op != `NCA_OP_CLC && exec_op != `NCA_OP_STC)
        |=> $stable(cf_r))
        else $error("Carry changed on an instruction that keeps it.");

    daa_adjust_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE15
        (do_exec && exec_op == `NCA_OP_DAA && (acc_r > 4'h9 || cf_r))
        |=> acc_r == $past(acc_r) + 4'h6 && cf_r)
        else $error("Decimal adjust did not add six and set carry.");

    ptr_load_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE13
        (do_exec && exec_op == `NCA_OP_MOV_P01_X)
        |=> {wr_r[1], wr_r[0]} == $past(byte_r))
        else $error("Pointer pair load wrote the wrong byte.");

    acc_timing_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE11
        state_r != nca_pkg::NCA_LAST_STATE |=> $stable(acc_r) && $stable(cf_r))
        else $error("Accumulator or carry changed outside the last state.");

    r4_load_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) // RULE14
        (do_exec && exec_op == `NCA_OP_MOV_R4_X) |=> wr_r[4] == $past(byte_r[3:0]))
        else $error("Fifth working register load failed.");

endmodule // nca_core

// ==== testbench/nca_prog_rom.sv ====
// Program memory model that answers the core's instruction fetches.
`timescale 1ns/1ps
module nca_prog_rom
#(
    parameter int PC_WIDTH = 12
)
(
    input  wire logic [PC_WIDTH-1:0] i_addr,
    output logic      [7:0]          o_data
);
    logic [7:0] mem [0:(1<<PC_WIDTH)-1];

    // Unwritten words read as zero, which the core runs as a no-op.
    initial
    begin
        for (int i = 0; i < (1 << PC_WIDTH); i++) mem[i] = 8'h00;
    end

    // Reads settle within the same clock, long before the third state samples the byte.
    assign o_data = mem[i_addr];
endmodule // nca_prog_rom

// ==== testbench/tb.sv ====
// Self-checking testbench for the nibble core running a program from the memory model.
`timescale 1ns/1ps
module tb;
    // ************************************************************
    // Signals, program table and design instances
    // ************************************************************
    localparam int N_ROWS = 62;
    logic        ref_clk;
    logic        resetn;
    logic [7:0]  prog_data;
    logic [11:0] prog_addr;
    logic [3:0]  acc;
    logic        carry;
    logic [1:0]  state;
    int          failures = 0;
    int          n_tests  = 0;
    // Each row: opcode, operand byte, expected accumulator, expected carry.
    logic [23:0] rows [N_ROWS] = '{
        24'h501200, 24'h750050, 24'h060050, 24'h790090, 24'h0900e0, 24'h080031,
        24'h080090, 24'h0a0040, 24'h0b00f1, 24'h0b0090, 24'h400811, 24'h4103e1,
        24'h2a00e0, 24'h360041, 24'h3600a1, 24'h2a00a0, 24'h720020, 24'h360020,
        24'h2b0021, 24'h7c00c1, 24'h1a0041, 24'h1b0051, 24'h1c0001, 24'h7a00a1,
        24'h1d00a1, 24'h040001, 24'h7c00c1, 24'h1e00c1, 24'h730031, 24'h1f0031,
        24'h0400f1, 24'h420661, 24'h4409f1, 24'h4305a1, 24'h2900a1, 24'h700001,
        24'h2800a1, 24'h4607a1, 24'h280071, 24'h180071, 24'h280081, 24'h190081,
        24'h190081, 24'h280061, 24'h513461, 24'h700001, 24'h070001, 24'h0f0001,
        24'h0500f1, 24'h0e00f1, 24'h050001, 24'h0d0001, 24'h0c0001, 24'h0400f1,
        24'h310001, 24'h3f00f1, 24'h240041, 24'h220011, 24'h260031, 24'h200021,
        24'h100021, 24'h200031
    };

    nca_core #(.PC_WIDTH(12), .RAM_DEPTH(256)) u_nca_core (
        .I_REF_CLK   (ref_clk),
        .I_RESETN    (resetn),
        .I_PROG_DATA (prog_data),
        .O_PROG_ADDR (prog_addr),
        .O_ACC       (acc),
        .O_CARRY     (carry),
        .O_STATE     (state)
    );

    nca_prog_rom #(.PC_WIDTH(12)) u_nca_prog_rom (
        .i_addr (prog_addr),
        .o_data (prog_data)
    );

    // 25 MHz reference clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compares one value; all results fit in twelve bits.
    task automatic check(input string what, input logic [11:0] expv, input logic [11:0] seen);
        n_tests++;
        if (seen !== expv)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Two-byte opcodes live in the 4x and 5x groups.
    function automatic int op_bytes(input logic [7:0] op);
        return (op[7:4] == 4'h4 || op[7:4] == 4'h5) ? 2 : 1;
    endfunction

    // Waits, bounded, for the last state; sampling at the falling edge avoids edge races.
    task automatic wait_last();
        int n;
        n = 0;
        while (state !== 2'b10 && n < 8)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("last state reached", 12'h002, {10'h0, state});
    endtask

    task automatic run_table();
        int pc;
        int nb;
        pc = 0;
        for (int i = 0; i < N_ROWS; i++)
        begin
            nb = op_bytes(rows[i][23:16]);
            for (int k = 0; k < nb; k++)
            begin
                wait_last();
                check("fetch address", 12'(pc + k), prog_addr);
                @(negedge ref_clk);
            end
            // Results must be visible right after the last cycle the instruction owns.
            check("accumulator", {8'h00, rows[i][7:4]}, {8'h00, acc});
            check("carry", {11'h0, rows[i][0]}, {11'h0, carry});
            pc += nb;
        end
        $display("table test done");
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        int a;
        int n;
        resetn = 1'b0;
        // Load after time zero, so the model's own clearing of its words cannot wipe the program.
        @(negedge ref_clk);
        a = 0;
        for (int i = 0; i < N_ROWS; i++)
        begin
            u_nca_prog_rom.mem[a] = rows[i][23:16];
            if (op_bytes(rows[i][23:16]) == 2) u_nca_prog_rom.mem[a + 1] = rows[i][15:8];
            a += op_bytes(rows[i][23:16]);
        end
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        run_table();
        // Reset in mid-run must clear the sequencer, counter and flags.
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("reset state", 12'h000, {10'h0, state});
        check("reset address", 12'h000, prog_addr);
        check("reset accumulator", 12'h000, {8'h00, acc});
        check("reset carry", 12'h000, {11'h0, carry});
        @(posedge ref_clk);
        resetn <= 1'b1;
        n = 0;
        while (state !== 2'b01 && n < 8)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("restart address", 12'h000, prog_addr);
        @(negedge ref_clk);
        check("third state", 12'h003, {10'h0, state});
        @(negedge ref_clk);
        check("fourth state", 12'h002, {10'h0, state});
        $display("reset test done");
        run_table();
        complete_run();
    end

    // Both table runs take well under 1000 clocks; four times that means a hang.
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        failures++;
        $display("mismatch watchdog expected finish seen hang");
        complete_run();
    end
endmodule // tb
